//--- hw/cwu_pkg.sv
// Constants, register map and types of the complementary waveform unit.
// Assumes an APB slave with byte addresses in the low eight address bits.
package cwu_pkg;

	// ************************************************************
	// Register map, one aligned 32-bit word per register.
	// ************************************************************
	localparam logic [7:0] CWU_OFF_CTRL0 = 8'h00;
	localparam logic [7:0] CWU_OFF_CTRL1 = 8'h04;
	localparam logic [7:0] CWU_OFF_CLKSEL = 8'h08;
	localparam logic [7:0] CWU_OFF_SDCTRL = 8'h0C;
	localparam logic [7:0] CWU_OFF_SDSRC = 8'h10;
	localparam logic [7:0] CWU_OFF_DBRISE = 8'h14;
	localparam logic [7:0] CWU_OFF_DBFALL = 8'h18;
	localparam logic [7:0] CWU_OFF_STEER = 8'h1C;
	localparam logic [7:0] CWU_OFF_IRQSTAT = 8'h20;
	localparam logic [7:0] CWU_OFF_IRQMASK = 8'h24;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int CWU_EN_BIT = 7;
	localparam int CWU_LD_BIT = 6;
	localparam int CWU_IN_BIT = 5;
	localparam int CWU_SD_BIT = 7;
	localparam int CWU_REN_BIT = 6;
	localparam int CWU_LSBD_LO = 4;
	localparam int CWU_LSAC_LO = 2;
	localparam int CWU_CS_BIT = 0;
	localparam int CWU_DB_W = 6;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [2:0] CWU_MODE_RST = 3'h0;
	localparam logic [3:0] CWU_POL_RST = 4'h0;
	localparam logic [1:0] CWU_LSBD_RST = 2'h1;
	localparam logic [1:0] CWU_LSAC_RST = 2'h1;
	localparam logic [31:0] CWU_WORD_ZERO = 32'h0000_0000;

	// ************************************************************
	// Output modes, in code order 000 to 111.
	// ************************************************************
	typedef enum logic [2:0] {
		CWU_MODE_ASYNC_STEER, CWU_MODE_SYNC_STEER, CWU_MODE_FWD_BRIDGE, CWU_MODE_REV_BRIDGE,
		CWU_MODE_HALF_BRIDGE, CWU_MODE_PUSH_PULL, CWU_MODE_RSVD6, CWU_MODE_RSVD7
	} cwu_mode_t;

	// Shutdown override level codes.
	localparam logic [1:0] CWU_LVL_INACTIVE = 2'h0;
	localparam logic [1:0] CWU_LVL_TRI = 2'h1;
	localparam logic [1:0] CWU_LVL_LOW = 2'h2;
	localparam logic [1:0] CWU_LVL_HIGH = 2'h3;

	// Dead-band buffer load sequencer.
	typedef enum logic [1:0] {CWU_LD_IDLE, CWU_LD_WAIT_FALL, CWU_LD_WAIT_RISE} cwu_ld_state_t;

endpackage

//--- hw/cwu_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no multi-bit coherency is given.
`timescale 1ns/1ps
module cwu_sync #(
	parameter int W = 1
) (
	input wire logic pclk, // Module clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [W-1:0] async_in, // Levels from outside the clock domain.
	output logic [W-1:0] sync_out // Levels safe to use in the clock domain.
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} cwu_sync_st_t;

	cwu_sync_st_t s;
	cwu_sync_st_t next_s;

	// The first stage feeds only the second, to give metastability a full cycle.
	always_comb begin
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
	end

	// Both stages clear under reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stage2;

endmodule // cwu_sync

//--- hw/cwu_top.sv
// Complementary waveform unit: APB registers, shutdown and restart, dead band and output stage.
// Assumes data_in and shutdown_in_n are asynchronous pins and sleep_mode is on pclk.
//
// What this block does
// - After the shutdown flag clears, outputs resume at the first data rising edge.
// - Software clear of the shutdown flag is ignored while any enabled condition holds.
// - With auto-restart on, hardware clears the shutdown flag once all conditions end.
// - The unit keeps working in sleep while its input sources stay active and the internal oscillator clocks it.
// - Dead-band counting continues in sleep when the internal oscillator clocks the unit.
// - Enabling the unit puts it in shutdown, so the override levels apply.
// - Bit 7 of control zero enables the unit when one.
// - Buffer-load copies dead-band buffers on the rising edge after the next falling edge.
// - Buffer-load can only be set while the unit is already enabled.
// - Mode field selects steering, bridge, half-bridge or push-pull; 110 and 111 reserved.
// - Bit 5 of control one reads the current data input level.
// - Polarity bits 3 to 0 invert outputs D, C, B and A.
// - Unimplemented control bits read zero and ignore writes.
// - Clock select bit 0 picks system oscillator at zero, internal oscillator at one.
// - Shutdown inputs are levels; shutdown persists while an enabled input is active.
`timescale 1ns/1ps
module cwu_top import cwu_pkg::*; #(
	parameter int SRC_N = 5
) (
	input wire logic pclk, // Module clock, 40 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready, always high.
	output logic pslverr, // APB error on unmapped address.
	input wire logic data_in, // Selected data input, asynchronous.
	input wire logic [SRC_N-1:0] shutdown_in_n, // Shutdown inputs, active low, asynchronous.
	input wire logic sleep_mode, // Device sleep, system oscillator stopped.
	output logic [3:0] wave_out, // Outputs D, C, B, A.
	output logic [3:0] wave_oe, // Output enables, high while driven.
	output logic clk_src_hfint, // Module clock select to the clock tree.
	output logic irq // Level interrupt.
);
	// ************************************************************
	// Parameter check.
	// ************************************************************
	if (SRC_N < 1 || SRC_N > 8) begin : g_bad_src
		$error("cwu_top: SRC_N must be 1 to 8");
	end

	typedef struct packed {
		logic en;
		logic ld;
		logic [2:0] mode;
		logic [3:0] pol;
		logic clk_sel;
		logic sd;
		logic ren;
		logic [1:0] lsbd;
		logic [1:0] lsac;
		logic [SRC_N-1:0] src_en;
		logic [CWU_DB_W-1:0] db_rise_buf;
		logic [CWU_DB_W-1:0] db_fall_buf;
		logic [CWU_DB_W-1:0] db_rise;
		logic [CWU_DB_W-1:0] db_fall;
		logic [7:0] steer;
		logic [7:0] steer_act;
		logic irq_stat;
		logic irq_mask;
		logic resume_wait;
		cwu_ld_state_t ld_state;
		logic data_q;
		logic [CWU_DB_W-1:0] db_cnt;
		logic pp_tog;
		logic [3:0] out;
		logic [3:0] oe;
		logic [31:0] rdata;
		logic slverr;
	} cwu_state_t;

	cwu_state_t s;
	cwu_state_t next_s;
	logic [SRC_N:0] pins_sync;
	logic din;
	logic [SRC_N-1:0] sd_pins_n;
	logic rise;
	logic fall;
	logic cond;
	logic wr;
	logic rd_setup;
	logic hit;
	logic tick;
	logic a_on;
	logic b_on;
	logic [3:0] raw;
	logic [3:0] shaped;
	logic [3:0] lvl_oe;
	logic [3:0] lvl_val;
	logic [1:0] lvl;
	logic [31:0] rd_word;

	// Pins pass two flops before any logic looks at them.
	cwu_sync #(.W(SRC_N + 1)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({shutdown_in_n, data_in}),
		.sync_out(pins_sync)
	);

	// ************************************************************
	// Decode and events.
	// ************************************************************
	assign din = pins_sync[0];
	assign sd_pins_n = pins_sync[SRC_N:1];
	assign rise = din & ~s.data_q;
	assign fall = ~din & s.data_q;
	assign cond = |(s.src_en & ~sd_pins_n);
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign tick = ~sleep_mode | s.clk_sel;
	assign a_on = s.data_q & (s.db_cnt >= s.db_rise);
	assign b_on = ~s.data_q & (s.db_cnt >= s.db_fall);

	// Address decode shared by read mux and error answer.
	always_comb begin
		hit = 1'b1;
		rd_word = CWU_WORD_ZERO;
		case (paddr)
			CWU_OFF_CTRL0: rd_word = {24'h0, s.en, s.ld, 3'h0, s.mode};
			CWU_OFF_CTRL1: rd_word = {24'h0, 2'h0, din, 1'h0, s.pol};
			CWU_OFF_CLKSEL: rd_word = {31'h0, s.clk_sel};
			CWU_OFF_SDCTRL: rd_word = {24'h0, s.sd, s.ren, s.lsbd, s.lsac, 2'h0};
			CWU_OFF_SDSRC: rd_word = 32'(s.src_en);
			CWU_OFF_DBRISE: rd_word = 32'(s.db_rise_buf);
			CWU_OFF_DBFALL: rd_word = 32'(s.db_fall_buf);
			CWU_OFF_STEER: rd_word = {24'h0, s.steer};
			CWU_OFF_IRQSTAT: rd_word = {31'h0, s.irq_stat};
			CWU_OFF_IRQMASK: rd_word = {31'h0, s.irq_mask};
			default: hit = 1'b0;
		endcase
	end

	// Raw waveform per mode, before polarity; order is D, C, B, A.
	always_comb begin
		case (cwu_mode_t'(s.mode))
			CWU_MODE_ASYNC_STEER, CWU_MODE_SYNC_STEER: begin
				raw = (s.steer_act[3:0] & {4{s.data_q}}) | (~s.steer_act[3:0] & s.steer_act[7:4]);
			end
			CWU_MODE_FWD_BRIDGE: raw = {s.data_q, 1'b0, 1'b0, 1'b1};
			CWU_MODE_REV_BRIDGE: raw = {1'b0, 1'b1, s.data_q, 1'b0};
			CWU_MODE_HALF_BRIDGE: raw = {b_on, a_on, b_on, a_on};
			CWU_MODE_PUSH_PULL: begin
				raw = {s.data_q & ~s.pp_tog, s.data_q & s.pp_tog, s.data_q & ~s.pp_tog, s.data_q & s.pp_tog};
			end
			default: raw = 4'h0;
		endcase
		shaped = raw ^ s.pol;
	end

	// Shutdown override per output: A and C follow one field, B and D the other.
	always_comb begin
		lvl_oe = 4'hF;
		lvl_val = 4'h0;
		lvl = CWU_LVL_INACTIVE;
		for (int i = 0; i < 4; i++) begin
			lvl = (i % 2 == 0) ? s.lsac : s.lsbd;
			case (lvl)
				CWU_LVL_HIGH: lvl_val[i] = 1'b1;
				CWU_LVL_LOW: lvl_val[i] = 1'b0;
				CWU_LVL_TRI: lvl_oe[i] = 1'b0;
				default: lvl_val[i] = s.pol[i];
			endcase
		end
	end

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.data_q = din;
		// Hardware clear first so a register write or a live condition overrides it.
		// automatic restart
		if (s.sd && s.ren && !cond) begin
			next_s.sd = 1'b0;
		end
		if (wr) begin
			case (paddr)
				CWU_OFF_CTRL0: begin
					next_s.en = pwdata[CWU_EN_BIT];
					if (pwdata[CWU_LD_BIT] && s.en) begin
						next_s.ld = 1'b1;
					end
					next_s.mode = pwdata[2:0];
				end
				CWU_OFF_CTRL1: next_s.pol = pwdata[3:0];
				CWU_OFF_CLKSEL: next_s.clk_sel = pwdata[CWU_CS_BIT];
				CWU_OFF_SDCTRL: begin
					next_s.ren = pwdata[CWU_REN_BIT];
					next_s.lsbd = pwdata[CWU_LSBD_LO +: 2];
					next_s.lsac = pwdata[CWU_LSAC_LO +: 2];
					if (pwdata[CWU_SD_BIT]) begin
						next_s.sd = 1'b1;
					end else if (!cond) begin
						next_s.sd = 1'b0;
					end
				end
				CWU_OFF_SDSRC: next_s.src_en = pwdata[SRC_N-1:0];
				CWU_OFF_DBRISE: begin
					next_s.db_rise_buf = pwdata[CWU_DB_W-1:0];
					next_s.db_rise = s.en ? s.db_rise : pwdata[CWU_DB_W-1:0];
				end
				CWU_OFF_DBFALL: begin
					next_s.db_fall_buf = pwdata[CWU_DB_W-1:0];
					next_s.db_fall = s.en ? s.db_fall : pwdata[CWU_DB_W-1:0];
				end
				CWU_OFF_STEER: next_s.steer = pwdata[7:0];
				CWU_OFF_IRQSTAT: next_s.irq_stat = s.irq_stat & ~pwdata[0];
				CWU_OFF_IRQMASK: next_s.irq_mask = pwdata[0];
				default: next_s.en = next_s.en;
			endcase
		end
		if (s.en && cond) begin
			next_s.sd = 1'b1;
		end
		if (!s.en && next_s.en) begin
			next_s.sd = 1'b1;
		end
		// A new shutdown event sets the sticky status; this wins over a clear.
		if (!s.sd && next_s.sd) begin
			next_s.irq_stat = 1'b1;
		end
		if (s.sd && !next_s.sd) begin
			next_s.resume_wait = 1'b1;
		end else if (s.resume_wait && rise) begin
			next_s.resume_wait = 1'b0;
		end
		case (s.ld_state)
			CWU_LD_IDLE: next_s.ld_state = s.ld ? CWU_LD_WAIT_FALL : CWU_LD_IDLE;
			CWU_LD_WAIT_FALL: next_s.ld_state = fall ? CWU_LD_WAIT_RISE : CWU_LD_WAIT_FALL;
			CWU_LD_WAIT_RISE: begin
				if (rise) begin
					next_s.db_rise = s.db_rise_buf;
					next_s.db_fall = s.db_fall_buf;
					next_s.ld = 1'b0;
					next_s.ld_state = CWU_LD_IDLE;
				end
			end
			default: next_s.ld_state = CWU_LD_IDLE;
		endcase
		if (!next_s.en) begin
			next_s.ld = 1'b0;
			next_s.ld_state = CWU_LD_IDLE;
		end
		// Synchronous steering takes new steering data only at a data rising edge.
		if (s.mode != CWU_MODE_SYNC_STEER || rise) begin
			next_s.steer_act = s.steer;
		end
		if (rise || fall) begin
			next_s.db_cnt = '0;
		end else if (tick && s.db_cnt != {CWU_DB_W{1'b1}}) begin
			next_s.db_cnt = s.db_cnt + 1'b1;
		end
		if (rise) begin
			next_s.pp_tog = ~s.pp_tog;
		end
		// Output stage: disabled drives nothing, shutdown or waiting shows the overrides.
		if (!s.en) begin
			next_s.out = 4'h0;
			next_s.oe = 4'h0;
		end else if (s.sd || s.resume_wait) begin
			next_s.out = lvl_val;
			next_s.oe = lvl_oe;
		end else begin
			next_s.out = shaped;
			next_s.oe = 4'hF;
		end
		// Read data and error are caught in the setup phase and shown in the access phase.
		if (rd_setup) begin
			next_s.rdata = pwrite ? CWU_WORD_ZERO : rd_word;
			next_s.slverr = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.mode <= CWU_MODE_RST;
			s.pol <= CWU_POL_RST;
			s.lsbd <= CWU_LSBD_RST;
			s.lsac <= CWU_LSAC_RST;
			s.ld_state <= CWU_LD_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = s.slverr & psel & penable;
	assign wave_out = s.out;
	assign wave_oe = s.oe;
	assign clk_src_hfint = s.clk_sel;
	assign irq = s.irq_stat & s.irq_mask;

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence sd_clear_write;
		wr && paddr == CWU_OFF_SDCTRL && !pwdata[CWU_SD_BIT];
	endsequence
	sequence ld_armed;
		s.en && s.ld && s.ld_state == CWU_LD_WAIT_RISE && rise;
	endsequence

	chk_sw_clear_block: assert property (sd_clear_write and s.en && cond |=> s.sd)
		else $error("shutdown cleared while condition present");
	chk_auto_restart: assert property (s.en && s.sd && s.ren && !cond && !wr |=> !s.sd)
		else $error("auto restart did not clear shutdown");
	chk_resume_edge: assert property ($fell(s.sd) |-> s.resume_wait ##1 (s.resume_wait || $past(rise)))
		else $error("resume not held for data rising edge");
	chk_enable_sd: assert property ($rose(s.en) |-> s.sd ##1 (s.oe == $past(lvl_oe) || !s.sd))
		else $error("enable did not start in shutdown");
	chk_ld_gate: assert property (wr && paddr == CWU_OFF_CTRL0 && pwdata[CWU_LD_BIT] && !s.en |=> !s.ld)
		else $error("load accepted while disabled");
	chk_ld_copy: assert property (ld_armed |=> !s.ld && s.db_rise == $past(s.db_rise_buf))
		else $error("dead band buffers not loaded");
	chk_level_sd: assert property (s.en && cond |=> s.sd)
		else $error("shutdown not held by active input");
	chk_invert_out: assert property (s.en && !s.sd && !s.resume_wait && s.mode == CWU_MODE_ASYNC_STEER
		&& s.steer_act[3:0] == 4'h0 |=> wave_out == $past(s.steer_act[7:4] ^ s.pol))
		else $error("polarity not applied");
	chk_in_readback: assert property (rd_setup && !pwrite && paddr == CWU_OFF_CTRL1
		|=> prdata[CWU_IN_BIT] == $past(din))
		else $error("input readback wrong");
	chk_unimpl_zero: assert property (rd_setup && paddr == CWU_OFF_CTRL0 |=> prdata[5:3] == 3'h0
		&& prdata[31:8] == 24'h0)
		else $error("unimplemented bits not zero");
	chk_sleep_count: assert property (sleep_mode && s.clk_sel && !rise && !fall && s.db_cnt < 6'h3F
		|=> s.db_cnt == $past(s.db_cnt) + 6'h01)
		else $error("dead band stalled in sleep");

endmodule // cwu_top

//--- tb/cwu_switch_model.sv
// Model of the external power switch stages hanging on the four unit outputs.
// Assumes each pin has a weak pull-down that holds the switch off when undriven.
`timescale 1ns/1ps
module cwu_switch_model (
	input wire logic [3:0] wave_out, // Levels from the unit, D to A.
	input wire logic [3:0] wave_oe, // Drive enables from the unit.
	output logic [3:0] pin_level // Gate level seen by each switch.
);
	// An undriven pin falls to the pull-down, so a released output never keeps its last level.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = wave_oe[i] ? wave_out[i] : 1'b0;
		end
	end
endmodule // cwu_switch_model

//--- tb/cwu_top_test.sv
// Self-checking bench of the complementary waveform unit over APB.
// Assumes the package, the design and the switch stage model are compiled first.
`timescale 1ns/1ps
module cwu_top_test import cwu_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, data_in, sleep_mode, pready, pslverr, clk_src_hfint, irq, ev;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd, rv;
	logic [4:0] shutdown_in_n;
	logic [3:0] wave_out, wave_oe, pin_level, pol;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	int k;

	cwu_top #(.SRC_N(5)) cwu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_in(data_in), .shutdown_in_n(shutdown_in_n), .sleep_mode(sleep_mode),
		.wave_out(wave_out), .wave_oe(wave_oe), .clk_src_hfint(clk_src_hfint), .irq(irq));
	cwu_switch_model cwu_switch_model_i (.wave_out(wave_out), .wave_oe(wave_oe), .pin_level(pin_level));

	// ************************************************************
	// Clock, timeout and helpers.
	// ************************************************************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// A hung handshake ends the run here rather than never.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Steering output: data level on every pin, each flipped by its polarity bit.
	function automatic logic [31:0] steer_exp(input logic d, input logic [3:0] p);
		return {28'h0, {4{d}} ^ p};
	endfunction

	// Shutdown control word with override levels B/D high and A/C low.
	function automatic logic [31:0] sdw(input logic sd, input logic ren);
		return {24'h0, sd, ren, 6'b111000};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge; request held until pready is seen.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rv, exp);
	endtask

	// Waits cover the two-flop synchroniser, edge register and output register.
	task automatic set_data(input logic v);
		data_in <= v;
		repeat (8) @(posedge pclk);
	endtask

	task automatic nxt();
		rnd = lfsr_next(rnd);
		pol = rnd[3:0];
		k = rnd[7:0] % 5;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		{psel, penable, pwrite, data_in, sleep_mode, presetn} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		shutdown_in_n = 5'h1F;
		rnd = 32'd79111;
		nxt();
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pin_level, 32'h0);
		rdchk(CWU_OFF_CTRL0, 32'h0);
		rdchk(CWU_OFF_CTRL1, 32'h0);
		rdchk(CWU_OFF_CLKSEL, 32'h0);
		rdchk(CWU_OFF_SDCTRL, 32'h14);
		$display("test reset finished");
		// Every bit written, unimplemented ones must stay clear.
		wr(CWU_OFF_CTRL1, 32'hFFFF_FFFF);
		rdchk(CWU_OFF_CTRL1, 32'h0F);
		wr(CWU_OFF_CLKSEL, 32'hFFFF_FFFF);
		rdchk(CWU_OFF_CLKSEL, 32'h1);
		chk(clk_src_hfint, 32'h1);
		wr(CWU_OFF_CLKSEL, 32'h0);
		chk(clk_src_hfint, 32'h0);
		for (int m = 0; m < 8; m++) begin
			wr(CWU_OFF_CTRL0, 32'h38 | m);
			rdchk(CWU_OFF_CTRL0, m);
		end
		wr(CWU_OFF_CTRL0, 32'hFFFF_FFFF);
		rdchk(CWU_OFF_CTRL0, 32'h87);
		rdchk(CWU_OFF_SDCTRL, 32'h94);
		wr(CWU_OFF_CTRL0, 32'h0);
		rdchk(CWU_OFF_CTRL0, 32'h0);
		wr(8'h28, 32'hFF);
		chk(ev, 32'h1);
		rdchk(8'h28, 32'h0);
		chk(ev, 32'h1);
		$display("test fields finished");
		wr(CWU_OFF_CTRL1, pol);
		wr(CWU_OFF_STEER, 32'h0F);
		wr(CWU_OFF_SDCTRL, sdw(1'b0, 1'b0));
		wr(CWU_OFF_SDSRC, 32'h0);
		wr(CWU_OFF_CTRL0, 32'h80);
		set_data(1'b1);
		chk(wave_out, 32'hA);
		chk(wave_oe, 32'hF);
		rdchk(CWU_OFF_SDCTRL, sdw(1'b1, 1'b0));
		rdchk(CWU_OFF_IRQSTAT, 32'h1);
		chk(irq, 32'h0);
		wr(CWU_OFF_IRQMASK, 32'h1);
		chk(irq, 32'h1);
		wr(CWU_OFF_IRQSTAT, 32'h1);
		chk(irq, 32'h0);
		wr(CWU_OFF_SDCTRL, sdw(1'b0, 1'b0));
		repeat (4) @(posedge pclk);
		chk(wave_out, 32'hA);
		// Data is still high, so a low level is needed before the next rise can release the outputs.
		set_data(1'b0);
		for (int i = 0; i < 3; i++) begin
			nxt();
			wr(CWU_OFF_CTRL1, pol);
			set_data(1'b1);
			chk(wave_out, steer_exp(1'b1, pol));
			chk(pin_level, steer_exp(1'b1, pol));
			rdchk(CWU_OFF_CTRL1, {26'h0, 1'b1, 1'b0, pol});
			set_data(1'b0);
			chk(wave_out, steer_exp(1'b0, pol));
			rdchk(CWU_OFF_CTRL1, {28'h0, pol});
		end
		// Steering disabled on every output: each pin shows its override data bit, inverted by polarity.
		wr(CWU_OFF_STEER, 32'h50);
		repeat (4) @(posedge pclk);
		chk(wave_out, {28'h0, 4'h5 ^ pol});
		wr(CWU_OFF_STEER, 32'h0F);
		repeat (4) @(posedge pclk);
		$display("test steering finished");
		// Pin shutdown with restart by software.
		wr(CWU_OFF_SDSRC, 32'h1 << k);
		shutdown_in_n[k] <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(wave_out, 32'hA);
		chk(irq, 32'h1);
		wr(CWU_OFF_SDCTRL, sdw(1'b0, 1'b0));
		rdchk(CWU_OFF_SDCTRL, sdw(1'b1, 1'b0));
		shutdown_in_n[k] <= 1'b1;
		repeat (8) @(posedge pclk);
		rdchk(CWU_OFF_SDCTRL, sdw(1'b1, 1'b0));
		wr(CWU_OFF_IRQSTAT, 32'h1);
		chk(irq, 32'h0);
		wr(CWU_OFF_SDCTRL, sdw(1'b0, 1'b0));
		rdchk(CWU_OFF_SDCTRL, sdw(1'b0, 1'b0));
		set_data(1'b1);
		chk(wave_out, steer_exp(1'b1, pol));
		$display("test software restart finished");
		// Pin shutdown with hardware restart.
		nxt();
		wr(CWU_OFF_SDSRC, 32'h1 << k);
		wr(CWU_OFF_SDCTRL, sdw(1'b0, 1'b1));
		wr(CWU_OFF_CTRL1, pol);
		shutdown_in_n[k] <= 1'b0;
		repeat (8) @(posedge pclk);
		rdchk(CWU_OFF_SDCTRL, sdw(1'b1, 1'b1));
		shutdown_in_n[k] <= 1'b1;
		repeat (8) @(posedge pclk);
		rdchk(CWU_OFF_SDCTRL, sdw(1'b0, 1'b1));
		chk(wave_out, 32'hA);
		set_data(1'b0);
		set_data(1'b1);
		chk(wave_out, steer_exp(1'b1, pol));
		$display("test auto restart finished");
		// Buffer load waits for a falling then a rising data edge.
		// While enabled the new rising dead band waits in the buffer until the load sequence ends.
		wr(CWU_OFF_DBRISE, 32'h5);
		wr(CWU_OFF_CTRL0, 32'hC0);
		rdchk(CWU_OFF_CTRL0, 32'hC0);
		set_data(1'b0);
		rdchk(CWU_OFF_CTRL0, 32'hC0);
		set_data(1'b1);
		rdchk(CWU_OFF_CTRL0, 32'h80);
		// Sleep on the internal oscillator keeps the outputs following data.
		wr(CWU_OFF_CLKSEL, 32'h1);
		sleep_mode <= 1'b1;
		set_data(1'b0);
		chk(wave_out, steer_exp(1'b0, pol));
		wr(CWU_OFF_CTRL0, 32'h84);
		set_data(1'b1);
		// Output A is still inside the five-count rising dead band; B is off while data is high.
		chk(wave_out[1:0], {30'h0, pol[1], pol[0]});
		repeat (4) @(posedge pclk);
		chk(wave_out[1:0], {30'h0, pol[1], ~pol[0]});
		sleep_mode <= 1'b0;
		$display("test sleep finished");
		// A second reset in mid-run.
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(wave_oe, 32'h0);
		rdchk(CWU_OFF_CTRL0, 32'h0);
		rdchk(CWU_OFF_CLKSEL, 32'h0);
		$display("test second reset finished");
		finish_test();
	end
endmodule // cwu_top_test
